// ==== pkg/sbc_cfg_map.svh ====
// Register map, field positions, reset values and counts of the second
// frequency set, clock divider, oscillator current and modem registers.
// Assumes byte-wide registers reached by a byte address on one clock.
`ifndef SBC_CFG_MAP_SVH
`define SBC_CFG_MAP_SVH

// Register addresses
`define SBC_ADDR_FREQ_HIGH   8'h08
`define SBC_ADDR_FREQ_MID    8'h09
`define SBC_ADDR_FREQ_LOW    8'h0A
`define SBC_ADDR_CLOCK_DIV   8'h0B
`define SBC_ADDR_OSC_CURRENT 8'h0C
`define SBC_ADDR_MODEM       8'h0D

// Reset values of whole registers
`define SBC_RST_FREQ_HIGH    8'h83
`define SBC_RST_FREQ_MID     8'hBD
`define SBC_RST_FREQ_LOW     8'hF9
`define SBC_RST_CLOCK_DIV    8'h50
`define SBC_RST_OSC_CURRENT  8'h88
`define SBC_RST_MODEM        8'h30

// Field positions
`define SBC_FLD_FREQ_LOW     7:1
`define SBC_FLD_DITHER       0
`define SBC_FLD_REF_DIV      7:5
`define SBC_FLD_MDIV_FIRST   4:2
`define SBC_FLD_MDIV_SECOND  1:0
`define SBC_FLD_OSC_FIRST    7:4
`define SBC_FLD_OSC_SECOND   3:0
`define SBC_FLD_ADC_DIV      6:4
`define SBC_FLD_SCRAMBLE     2
`define SBC_FLD_FORMAT       1:0
`define SBC_MODEM_WR_MASK    8'h77

// Codes and counts
`define SBC_CODE_UNSUPPORTED 3'h0
`define SBC_CODE_FIRST_OK    3'h1
`define SBC_REF_TICK_STEP    11'h002
`define SBC_BAUD_MID         3'h3
`define SBC_BAUD_LAST        3'h7
`define SBC_PN_SEED          9'h1FF
`define SBC_PN_TAP_HIGH      8
`define SBC_PN_TAP_LOW       4

`endif

// ==== pkg/sbc_pkg.sv ====
// Types shared by the device end and the host end of the config link.
// Assumes the map header is on the include path.
`default_nettype none

package sbc_pkg;

    // Line data formats, in register code order
    typedef enum logic [1:0] {
        FmtNrz,
        FmtManchester,
        FmtUartLow,
        FmtUartHigh
    } sbc_fmt_t;

    typedef enum logic {
        HostIdle,
        HostRead
    } sbc_host_st_t;

    // Whole state of the device end
    typedef struct packed {
        logic [7:0]  freqHigh;
        logic [7:0]  freqMid;
        logic [7:0]  freqLow;
        logic [7:0]  clkDiv;
        logic [7:0]  oscCur;
        logic [7:0]  modem;
        logic [7:0]  rdData;
        logic        rdValid;
        logic        rxMeta;
        logic        rxSync;
        logic [2:0]  refCnt;
        logic [10:0] modemAcc;
        logic [2:0]  baudCnt;
        logic [4:0]  adcCnt;
        logic [8:0]  pnState;
        logic        txHold;
        logic        txLine;
        logic        rxBit;
        logic        rxBitValid;
        logic        dataClockPin;
        logic        baudTick;
        logic        adcTick;
    } sbc_dev_state_t;

    // Whole state of the host end
    typedef struct packed {
        sbc_host_st_t state;
        logic         wrEn;
        logic         rdEn;
        logic [7:0]   addr;
        logic [7:0]   wrData;
        logic         cmdReady;
        logic [7:0]   rspData;
        logic         rspValid;
        logic         cmdRejected;
    } sbc_host_state_t;

endpackage : sbc_pkg

`default_nettype wire

// ==== pkg/sbc_cfg_if.sv ====
// Register link between the configuring host and the device end.
// Assumes both ends run on the same clock; no tristate on this link.
`default_nettype none

interface sbc_cfg_if (
    input wire logic clk_sys
);
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       rdValid;

    modport dev (
        input  clk_sys,
        input  wrEn,
        input  rdEn,
        input  addr,
        input  wrData,
        output rdData,
        output rdValid
    );

    modport host (
        input  clk_sys,
        output wrEn,
        output rdEn,
        output addr,
        output wrData,
        input  rdData,
        input  rdValid
    );
endinterface : sbc_cfg_if

`default_nettype wire

// ==== hdl/sbc_device.sv ====
// Device end: second frequency set, clock dividers, oscillator current
// and modem settings, with the baud, ADC and scrambled data path.
// Assumes clk_sys is the crystal clock and rxPin is an unsynced pin.
`default_nettype none

`include "sbc_cfg_map.svh"

module sbc_device (
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    sbc_cfg_if.dev               cfg,
    input  wire logic            txBit,
    input  wire logic            rxPin,
    output logic [22:0]          secondFreqWord,
    output logic                 secondSetDitherEn,
    output logic [3:0]           oscCurrentFirstSet,
    output logic [3:0]           oscCurrentSecondSet,
    output logic                 scramblerEnable,
    output sbc_pkg::sbc_fmt_t    dataFormat,
    output logic                 txLine,
    output logic                 rxBit,
    output logic                 rxBitValid,
    output logic                 dataClockPin,
    output logic                 baudTick,
    output logic                 adcTick
);
    import sbc_pkg::*;

    sbc_dev_state_t q;
    sbc_dev_state_t d;

    // First modem divider, doubled so 2.5 steps stay whole
    function automatic logic [10:0] firstDivTwice(input logic [2:0] code);
        unique case (code)
            3'h0: firstDivTwice = 11'h005;
            3'h1: firstDivTwice = 11'h006;
            3'h2: firstDivTwice = 11'h008;
            3'h3: firstDivTwice = 11'h00F;
            3'h4: firstDivTwice = 11'h019;
            3'h5: firstDivTwice = 11'h050;
            3'h6: firstDivTwice = 11'h060;
            3'h7: firstDivTwice = 11'h080;
        endcase
    endfunction : firstDivTwice

    // ADC divisor minus one; unsupported code runs as the smallest
    function automatic logic [4:0] adcLast(input logic [2:0] code);
        unique case (code)
            3'h0: adcLast = 5'h03;
            3'h1: adcLast = 5'h03;
            3'h2: adcLast = 5'h05;
            3'h3: adcLast = 5'h07;
            3'h4: adcLast = 5'h09;
            3'h5: adcLast = 5'h09;
            3'h6: adcLast = 5'h0D;
            3'h7: adcLast = 5'h0F;
        endcase
    endfunction : adcLast

    // Register read decode; reserved modem bits read back as zero
    function automatic logic [7:0] readReg(input sbc_dev_state_t s,
                                           input logic [7:0] a);
        unique case (a)
            `SBC_ADDR_FREQ_HIGH:   readReg = s.freqHigh;
            `SBC_ADDR_FREQ_MID:    readReg = s.freqMid;
            `SBC_ADDR_FREQ_LOW:    readReg = s.freqLow;
            `SBC_ADDR_CLOCK_DIV:   readReg = s.clkDiv;
            `SBC_ADDR_OSC_CURRENT: readReg = s.oscCur;
            `SBC_ADDR_MODEM:       readReg = s.modem;
            default:               readReg = 8'h00;
        endcase
    endfunction : readReg

    logic [2:0]  refLast;
    logic        refTick;
    logic [10:0] modemPeriod;
    logic [10:0] accStep;
    logic        modemTick;
    logic        scrOn;
    logic        pnBit;
    logic        syncMode;
    sbc_fmt_t    fmt;

    // Divider decode from the clock register, scrambler and format decode from the modem register
    always_comb begin
        refLast = q.clkDiv[`SBC_FLD_REF_DIV];
        if (refLast == `SBC_CODE_UNSUPPORTED) begin
            refLast = `SBC_CODE_FIRST_OK;
        end
        refTick = (q.refCnt == refLast);
        modemPeriod = firstDivTwice(q.clkDiv[`SBC_FLD_MDIV_FIRST])
                      << q.clkDiv[`SBC_FLD_MDIV_SECOND];
        accStep = q.modemAcc + `SBC_REF_TICK_STEP;
        modemTick = refTick && (accStep >= modemPeriod);
        scrOn = q.modem[`SBC_FLD_SCRAMBLE];
        pnBit = scrOn & q.pnState[`SBC_PN_TAP_HIGH];
        fmt = sbc_fmt_t'(q.modem[`SBC_FLD_FORMAT]);
        syncMode = (fmt == FmtNrz) || (fmt == FmtManchester);
    end

    // Next state of the whole device end
    always_comb begin
        d = q;
        d.rdValid = 1'b0;
        d.rxBitValid = 1'b0;
        d.baudTick = 1'b0;
        d.adcTick = 1'b0;

        // Register writes; unmapped addresses are ignored
        if (cfg.wrEn) begin
            unique case (cfg.addr)
                `SBC_ADDR_FREQ_HIGH:   d.freqHigh = cfg.wrData;
                `SBC_ADDR_FREQ_MID:    d.freqMid = cfg.wrData;
                `SBC_ADDR_FREQ_LOW:    d.freqLow = cfg.wrData;
                `SBC_ADDR_CLOCK_DIV:   d.clkDiv = cfg.wrData;
                `SBC_ADDR_OSC_CURRENT: d.oscCur = cfg.wrData;
                `SBC_ADDR_MODEM:
                    d.modem = cfg.wrData & `SBC_MODEM_WR_MASK;
                default: ;
            endcase
        end
        if (cfg.rdEn) begin
            d.rdData = readReg(q, cfg.addr);
            d.rdValid = 1'b1;
        end

        // Pin synchroniser, two stages before any use
        d.rxMeta = rxPin;
        d.rxSync = q.rxMeta;

        // Reference tick, then fractional modem clock
        d.refCnt = refTick ? 3'h0 : q.refCnt + 3'h1;
        if (refTick) begin
            d.modemAcc = modemTick ? accStep - modemPeriod : accStep;
        end

        // Eight modem ticks per symbol
        if (modemTick) begin
            d.baudCnt = q.baudCnt + 3'h1;
            d.baudTick = (q.baudCnt == `SBC_BAUD_LAST);
        end

        // A new divider restarts symbol timing; a stale accumulator
        // would otherwise burst modem ticks until it caught up
        if (cfg.wrEn && cfg.addr == `SBC_ADDR_CLOCK_DIV) begin
            d.refCnt = 3'h0;
            d.modemAcc = 11'h000;
            d.baudCnt = 3'h0;
        end

        // ADC clock from the crystal clock
        if (q.adcCnt >= adcLast(q.modem[`SBC_FLD_ADC_DIV])) begin
            d.adcCnt = 5'h00;
            d.adcTick = 1'b1;
        end else begin
            d.adcCnt = q.adcCnt + 5'h01;
        end

        // Scrambler advances once per symbol; reseeds while off
        if (!scrOn) begin
            d.pnState = `SBC_PN_SEED;
        end else if (d.baudTick) begin
            d.pnState = {q.pnState[7:0],
                         q.pnState[`SBC_PN_TAP_HIGH]
                         ^ q.pnState[`SBC_PN_TAP_LOW]};
        end

        // Transmit and receive paths by line format
        if (syncMode) begin
            if (d.baudTick) begin
                d.txHold = txBit ^ pnBit;
            end
            if (modemTick && q.baudCnt == `SBC_BAUD_MID) begin
                d.rxBit = q.rxSync ^ pnBit;
                d.rxBitValid = 1'b1;
            end
            // Manchester inverts in the second half of each symbol
            d.txLine = (fmt == FmtManchester)
                       ? d.txHold ^ d.baudCnt[2] : d.txHold;
            d.dataClockPin = d.baudCnt[2];
        end else begin
            // Transparent mode: no retiming, clock pin held static
            d.txLine = txBit;
            d.rxBit = q.rxSync;
            d.dataClockPin = (fmt == FmtUartHigh);
        end
    end

    // State register with synchronous reset to defaults
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
            q.freqHigh <= `SBC_RST_FREQ_HIGH;
            q.freqMid <= `SBC_RST_FREQ_MID;
            q.freqLow <= `SBC_RST_FREQ_LOW;
            q.clkDiv <= `SBC_RST_CLOCK_DIV;
            q.oscCur <= `SBC_RST_OSC_CURRENT;
            q.modem <= `SBC_RST_MODEM;
            q.pnState <= `SBC_PN_SEED;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign cfg.rdData = q.rdData;
    assign cfg.rdValid = q.rdValid;
    assign secondFreqWord = {q.freqHigh, q.freqMid,
                             q.freqLow[`SBC_FLD_FREQ_LOW]};
    assign secondSetDitherEn = q.freqLow[`SBC_FLD_DITHER];
    assign oscCurrentFirstSet = q.oscCur[`SBC_FLD_OSC_FIRST];
    assign oscCurrentSecondSet = q.oscCur[`SBC_FLD_OSC_SECOND];
    assign scramblerEnable = q.modem[`SBC_FLD_SCRAMBLE];
    assign dataFormat = sbc_fmt_t'(q.modem[`SBC_FLD_FORMAT]);
    assign txLine = q.txLine;
    assign rxBit = q.rxBit;
    assign rxBitValid = q.rxBitValid;
    assign dataClockPin = q.dataClockPin;
    assign baudTick = q.baudTick;
    assign adcTick = q.adcTick;

endmodule : sbc_device

`default_nettype wire

// ==== hdl/sbc_host.sv ====
// Host end: turns user commands into single register writes and reads.
// Assumes the device answers a read on the cycle after the request.
`default_nettype none

`include "sbc_cfg_map.svh"

module sbc_host (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    sbc_cfg_if.host          cfg,
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic [7:0]  cmdData,
    output logic             cmdReady,
    output logic [7:0]       rspData,
    output logic             rspValid,
    output logic             cmdRejected
);
    import sbc_pkg::*;

    sbc_host_state_t q;
    sbc_host_state_t d;
    logic            badCode;

    // Unsupported divisor codes must never reach the device
    always_comb begin
        badCode = 1'b0;
        if (cmdAddr == `SBC_ADDR_CLOCK_DIV) begin
            badCode = (cmdData[`SBC_FLD_REF_DIV]
                       == `SBC_CODE_UNSUPPORTED);
        end else if (cmdAddr == `SBC_ADDR_MODEM) begin
            badCode = (cmdData[`SBC_FLD_ADC_DIV]
                       == `SBC_CODE_UNSUPPORTED);
        end
    end

    // One command at a time; reads hold off until answered
    always_comb begin
        d = q;
        d.wrEn = 1'b0;
        d.rdEn = 1'b0;
        d.rspValid = 1'b0;
        d.cmdRejected = 1'b0;
        unique case (q.state)
            HostIdle: begin
                if (cmdValid && cmdWrite) begin
                    d.addr = cmdAddr;
                    // Reserved modem bits are always written as zero
                    d.wrData = (cmdAddr == `SBC_ADDR_MODEM)
                               ? cmdData & `SBC_MODEM_WR_MASK : cmdData;
                    d.wrEn = !badCode;
                    d.cmdRejected = badCode;
                end else if (cmdValid) begin
                    d.addr = cmdAddr;
                    d.rdEn = 1'b1;
                    d.cmdReady = 1'b0;
                    d.state = HostRead;
                end
            end
            HostRead: begin
                if (cfg.rdValid) begin
                    d.rspData = cfg.rdData;
                    d.rspValid = 1'b1;
                    d.cmdReady = 1'b1;
                    d.state = HostIdle;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
            q.state <= HostIdle;
            q.cmdReady <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cfg.wrEn = q.wrEn;
    assign cfg.rdEn = q.rdEn;
    assign cfg.addr = q.addr;
    assign cfg.wrData = q.wrData;
    assign cmdReady = q.cmdReady;
    assign rspData = q.rspData;
    assign rspValid = q.rspValid;
    assign cmdRejected = q.cmdRejected;

endmodule : sbc_host

`default_nettype wire

// ==== test/sbc_cfg_properties.sv ====
// Checker of the register link between the host end and the device end.
// Assumes it sees the link signals and the sync reset as plain inputs.
`default_nettype none

`include "sbc_cfg_map.svh"

module sbc_cfg_properties (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       wrEn,
    input wire logic       rdEn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic       rdValid
);
    logic [7:0] shadowQ [6];
    logic [7:0] expQ;
    logic [7:0] rdAddrQ;
    logic       mapped;
    logic [2:0] idx;

    // Only 08 to 0D hold a register; low bits give the slot
    assign mapped = addr >= `SBC_ADDR_FREQ_HIGH && addr <= `SBC_ADDR_MODEM;
    assign idx    = addr[2:0];

    // Shadow copy, so a read is judged against every earlier write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shadowQ <= '{`SBC_RST_FREQ_HIGH, `SBC_RST_FREQ_MID,
                `SBC_RST_FREQ_LOW, `SBC_RST_CLOCK_DIV,
                `SBC_RST_OSC_CURRENT, `SBC_RST_MODEM};
            expQ    <= 8'h00;
            rdAddrQ <= 8'h00;
        end else begin
            if (wrEn && mapped) begin
                shadowQ[idx] <= (addr == `SBC_ADDR_MODEM)
                    ? (wrData & `SBC_MODEM_WR_MASK) : wrData;
            end
            if (rdEn) begin
                expQ    <= mapped ? shadowQ[idx] : 8'h00;
                rdAddrQ <= addr;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_read_answer: assert property (rdEn |=> rdValid)
        else $error("Read strobe not answered on the next cycle");
    a_valid_cause: assert property (rdValid |-> $past(rdEn))
        else $error("Read answer without a read strobe");
    a_high_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_FREQ_HIGH |-> rdData == expQ)
        else $error("High frequency byte reads back wrong");
    a_mid_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_FREQ_MID |-> rdData == expQ)
        else $error("Mid frequency byte reads back wrong");
    a_low_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_FREQ_LOW |-> rdData == expQ)
        else $error("Low frequency byte reads back wrong");
    a_clkdiv_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_CLOCK_DIV |-> rdData == expQ)
        else $error("Clock divider byte reads back wrong");
    a_osc_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_OSC_CURRENT |-> rdData == expQ)
        else $error("Oscillator current byte reads back wrong");
    a_modem_readback: assert property (rdValid &&
        rdAddrQ == `SBC_ADDR_MODEM |-> rdData == expQ)
        else $error("Modem byte reads back wrong");
    a_refdiv_legal: assert property (wrEn &&
        addr == `SBC_ADDR_CLOCK_DIV
        |-> wrData[`SBC_FLD_REF_DIV] != `SBC_CODE_UNSUPPORTED)
        else $error("Reference divisor code zero written");
    a_adcdiv_legal: assert property (wrEn &&
        addr == `SBC_ADDR_MODEM
        |-> wrData[`SBC_FLD_ADC_DIV] != `SBC_CODE_UNSUPPORTED)
        else $error("Converter divisor code zero written");
endmodule : sbc_cfg_properties

`default_nettype wire

// ==== test/testbench.sv ====
// Bench joining the host end and the device end over the register link.
// Assumes the map header on the include path and a 40 MHz system clock.
`default_nettype none

`include "sbc_cfg_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_pkg::*;

    logic        clk_sys  = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        cmdValid = 1'b0;
    logic        cmdWrite = 1'b0;
    logic [7:0]  cmdAddr  = 8'h00;
    logic [7:0]  cmdData  = 8'h00;
    logic        txBit    = 1'b0;
    logic        rxPin    = 1'b1;
    logic        cmdReady, rspValid, cmdRejected, lastRej;
    logic [7:0]  rspData;
    logic [22:0] secondFreqWord;
    logic        ditherEn, scramblerEnable, txLine, dataClockPin;
    logic        baudTick, adcTick, rxBit, rxValid;
    int          rxCnt       = 0;
    logic [3:0]  oscFirst, oscSecond;
    sbc_fmt_t    dataFormat;
    int          errCount    = 0;
    int          totalChecks = 0;
    int          div1x2 [8]  = '{5, 6, 8, 15, 25, 80, 96, 128};
    int          adcTab [8]  = '{4, 4, 6, 8, 10, 10, 14, 16};
    logic [7:0]  addrTab [6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    logic [7:0]  rstTab [6]  = '{8'h83, 8'hBD, 8'hF9, 8'h50, 8'h88, 8'h30};
    logic [7:0]  wrTab [6]   = '{8'hA5, 8'h3C, 8'h5A, 8'hE6, 8'h4B, 8'hFF};
    logic [7:0]  expTab [6]  = '{8'hA5, 8'h3C, 8'h5A, 8'hE6, 8'h4B, 8'h77};

    // 25 ns period
    always #12.5 clk_sys = ~clk_sys;

    sbc_cfg_if cfgLink (.clk_sys(clk_sys));

    sbc_host i_sbc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg(cfgLink),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspData(rspData),
        .rspValid(rspValid), .cmdRejected(cmdRejected));

    sbc_device i_sbc_device (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .cfg(cfgLink), .txBit(txBit), .rxPin(rxPin),
        .secondFreqWord(secondFreqWord), .secondSetDitherEn(ditherEn),
        .oscCurrentFirstSet(oscFirst), .oscCurrentSecondSet(oscSecond),
        .scramblerEnable(scramblerEnable), .dataFormat(dataFormat),
        .txLine(txLine), .rxBit(rxBit), .rxBitValid(rxValid),
        .dataClockPin(dataClockPin), .baudTick(baudTick), .adcTick(adcTick));

    sbc_cfg_properties i_sbc_cfg_properties (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .wrEn(cfgLink.wrEn), .rdEn(cfgLink.rdEn),
        .addr(cfgLink.addr), .wrData(cfgLink.wrData),
        .rdData(cfgLink.rdData), .rdValid(cfgLink.rdValid));

    // Receive sample strobes, counted for the one-per-symbol check
    always @(negedge clk_sys) begin
        if (rxValid === 1'b1) begin
            rxCnt++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic printVerdict();
        $display("Checks %0d, mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : printVerdict

    // A wait that ran out ends the run rather than hanging it
    task automatic hang();
        errCount++;
        $display("MISMATCH at %0t: wait ran out", $time);
        printVerdict();
    endtask : hang

    // Entered at a falling edge; command is taken at the next rising edge
    task automatic sendCmd(input logic wr, input logic [7:0] a,
                           input logic [7:0] d);
        int n;
        n = 0;
        while (cmdReady !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 50) hang();
        end
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdAddr  = a;
        cmdData  = d;
        @(negedge clk_sys);
        lastRej  = cmdRejected;
        cmdValid = 1'b0;
        // One idle edge, so a next call never re-raises it at once
        @(negedge clk_sys);
    endtask : sendCmd

    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        int n;
        sendCmd(1'b0, a, 8'h00);
        n = 0;
        while (rspValid !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 10) hang();
        end
        d = rspData;
    endtask : regRead

    // Third interval is whole: the first two may straddle a divider change
    task automatic measure(input logic useAdc, output int cyc);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            cyc = 0;
            do begin
                @(negedge clk_sys);
                cyc++;
                n++;
                if (n > 9000) hang();
            end while ((useAdc ? adcTick : baudTick) !== 1'b1);
        end
    endtask : measure

    task automatic tryBaud(input int c, input int m, input int s);
        int cyc;
        sendCmd(1'b1, `SBC_ADDR_CLOCK_DIV, {c[2:0], m[2:0], s[1:0]});
        measure(1'b0, cyc);
        check(cyc, (c + 1) * div1x2[m] * (1 << s) * 4);
    endtask : tryBaud

    // Line and data clock pin sampled in each half of the next symbol
    task automatic sampleSym(output logic l1, output logic p1,
                             output logic l2, output logic p2);
        int n;
        n = 0;
        while (baudTick !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 2000) hang();
        end
        repeat (10) @(negedge clk_sys);
        l1 = txLine;
        p1 = dataClockPin;
        repeat (20) @(negedge clk_sys);
        l2 = txLine;
        p2 = dataClockPin;
    endtask : sampleSym

    // Main sequence; all stimulus changes at falling edges
    initial begin
        logic [7:0]  rd;
        int          cyc;
        logic        l1, p1, l2, p2;
        logic [29:0] bits;
        repeat (16) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            regRead(addrTab[i], rd);
            check(rd, rstTab[i]);
        end
        check(secondFreqWord, {8'd131, 8'd189, 7'd124});
        check({ditherEn, oscFirst, oscSecond}, 9'h188);
        check({scramblerEnable, dataFormat}, {1'b0, FmtNrz});
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            sendCmd(1'b1, addrTab[i], wrTab[i]);
        end
        for (int i = 0; i < 6; i++) begin
            regRead(addrTab[i], rd);
            check(rd, expTab[i]);
        end
        check(secondFreqWord, {8'hA5, 8'h3C, 7'h2D});
        check({ditherEn, oscFirst, oscSecond}, 9'h04B);
        check({scramblerEnable, dataFormat}, {1'b1, FmtUartHigh});
        check(dataClockPin, 1'b1);
        sendCmd(1'b1, 8'h0E, 8'h55);
        regRead(8'h0E, rd);
        check(rd, 8'h00);
        regRead(8'h07, rd);
        check(rd, 8'h00);
        $display("Test write and readback done");
        sendCmd(1'b1, `SBC_ADDR_CLOCK_DIV, 8'h1F);
        check(lastRej, 1'b1);
        sendCmd(1'b1, `SBC_ADDR_MODEM, 8'h05);
        check(lastRej, 1'b1);
        regRead(`SBC_ADDR_CLOCK_DIV, rd);
        check(rd, 8'hE6);
        regRead(`SBC_ADDR_MODEM, rd);
        check(rd, 8'h77);
        $display("Test refused codes done");
        for (int m = 0; m < 8; m++) tryBaud(1, m, 0);
        for (int s = 1; s < 4; s++) tryBaud(1, 0, s);
        for (int c = 2; c < 8; c++) tryBaud(c, 0, 0);
        for (int a = 1; a < 8; a++) begin
            sendCmd(1'b1, `SBC_ADDR_MODEM, {1'b0, a[2:0], 4'h0});
            check(lastRej, 1'b0);
            measure(1'b1, cyc);
            check(cyc, adcTab[a]);
        end
        $display("Test divider rates done");
        // Fastest symbol of 40 cycles keeps the pattern scenes short
        sendCmd(1'b1, `SBC_ADDR_CLOCK_DIV, 8'h20);
        txBit = 1'b1;
        for (int f = 0; f < 2; f++) begin
            sendCmd(1'b1, `SBC_ADDR_MODEM, 8'h30 | f[7:0]);
            sampleSym(l1, p1, l2, p2);
            sampleSym(l1, p1, l2, p2);
            check({l1, l2, p1, p2}, {~f[0], 1'b1, 2'b01});
            txBit = 1'b0;
        end
        for (int f = 2; f < 4; f++) begin
            sendCmd(1'b1, `SBC_ADDR_MODEM, 8'h30 | f[7:0]);
            txBit = 1'b1;
            repeat (6) @(negedge clk_sys);
            check({txLine, dataClockPin}, {1'b1, f[0]});
            txBit = 1'b0;
            repeat (6) @(negedge clk_sys);
            check({txLine, dataClockPin}, {1'b0, f[0]});
        end
        $display("Test line formats done");
        // Zeros sent through the scrambler must show the sequence itself
        sendCmd(1'b1, `SBC_ADDR_MODEM, 8'h34);
        sampleSym(l1, p1, l2, p2);
        for (int k = 0; k < 30; k++) begin
            sampleSym(bits[k], p1, l2, p2);
        end
        check(|bits, 1'b1);
        for (int k = 0; k < 21; k++) begin
            check(bits[k + 9], bits[k] ^ bits[k + 4]);
        end
        sendCmd(1'b1, `SBC_ADDR_MODEM, 8'h30);
        rxPin = 1'b0;
        sampleSym(l1, p1, l2, p2);
        sampleSym(l1, p1, l2, p2);
        check({l1, l2, rxBit}, 3'b000);
        rxPin = 1'b1;
        sampleSym(l1, p1, l2, p2);
        cyc = rxCnt;
        sampleSym(l1, p1, l2, p2);
        check(rxBit, 1'b1);
        check(rxCnt - cyc, 1);
        $display("Test scrambler done");
        printVerdict();
    end
endmodule : testbench

`default_nettype wire
